//--- art_pkg.sv
`default_nettype none
package art_pkg;
    // special-function-register addresses
    localparam logic [7:0] ADDR_CTRL = 8'h91;
    localparam logic [7:0] ADDR_RLD_LO = 8'h92;
    localparam logic [7:0] ADDR_RLD_HI = 8'h93;
    localparam logic [7:0] ADDR_CNT_LO = 8'h94;
    localparam logic [7:0] ADDR_CNT_HI = 8'h95;

    // control register field positions
    localparam int BIT_HI_OVF = 7;
    localparam int BIT_LO_OVF = 6;
    localparam int BIT_LO_IRQ_EN = 5;
    localparam int BIT_CAP_EN = 4;
    localparam int BIT_SPLIT = 3;
    localparam int BIT_RUN = 2;
    localparam int SEL_MSB = 1;
    localparam int SEL_LSB = 0;

    // reset and boundary values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;

    // alternate source encodings
    localparam logic [1:0] ALT_SYS12_A = 2'h0;
    localparam logic [1:0] ALT_EXT8 = 2'h1;
    localparam logic [1:0] ALT_SYS12_B = 2'h2;
    localparam logic [1:0] ALT_CMP = 2'h3;

    // divider terminal counts
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [3:0] DIV_ZERO = 4'h0;
    localparam logic [2:0] DIV8_LAST = 3'h7;
    localparam logic [2:0] DIV8_ZERO = 3'h0;
endpackage : art_pkg
`default_nettype wire

//--- art_sync_edge.sv
`default_nettype none
module art_sync_edge (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // asynchronous level in, rising-edge pulse out
    input wire logic async_in,
    output logic rise
);
    logic meta;
    logic sync;
    logic sync_d;

    // two-stage synchroniser; only the second stage is examined
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta <= 1'b0;
            sync <= 1'b0;
            sync_d <= 1'b0;
            rise <= 1'b0;
        end else begin
            meta <= async_in; // [RL14]
            sync <= meta;
            sync_d <= sync;
            rise <= sync & ~sync_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_rise_one_cycle: assert property (rise |=> !rise) // [RL14]
        else $error("edge pulse lasted more than one cycle");
endmodule : art_sync_edge
`default_nettype wire

//--- art_timer.sv
// Operation
// (RL1) high-byte overflow flag sets when the upper byte wraps FF to 00
// (RL2) in 16-bit mode high flag sets when count wraps FFFF to 0000
// (RL3) timer interrupt requested while enabled and high flag set
// (RL4) overflow flags are never cleared by hardware; software clears them
// (RL5) low-byte overflow flag sets whenever the lower byte wraps, any mode
// (RL6) low flag requests interrupt when low enable and timer interrupt enabled
// (RL7) capture-enable bit selects capture mode sampling count on triggers
// (RL8) split bit: 0 one 16-bit counter, 1 two 8-bit counters
// (RL9) timer counts only while run bit set; clear stops 16-bit counting
// (RL10) in split mode run bit gates only upper byte; lower always runs
// (RL11) select 00/10 core clock /12, 01 external oscillator /8, 11 comparator
// (RL12) capture trigger: select 00/01 comparator, 10/11 external oscillator /8
// (RL13) split bytes share alternate source; per-byte selector picks it or core clock
// (RL14) external sources are synchronised before touching the counter
// (RL15) 16-bit wrap loads the 16-bit reload value; with capture enabled the code wraps to zero instead
// (RL16) split bytes reload from their own reload byte on overflow
// (RL17) capture copies count into reload registers and sets high flag
// (RL18) per-byte selector set picks core clock, clear picks alternate source
// (RL19) each enabled counter increments by one per tick of its source
`default_nettype none
module art_timer (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // special-function-register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // per-byte clock selects and interrupt enable from outside registers
    input wire logic hi_byte_core_clk_sel,
    input wire logic lo_byte_core_clk_sel,
    input wire logic timer_irq_en,
    // asynchronous count and trigger sources
    input wire logic ext_osc_in,
    input wire logic cmp_in,
    // interrupt request
    output logic irq_req
);
    logic [7:0] tmr_ctrl_reg;
    logic [7:0] reload_lo;
    logic [7:0] reload_hi;
    logic [7:0] count_lo;
    logic [7:0] count_hi;
    logic [3:0] div12_cnt;
    logic [2:0] div8_cnt;
    logic sys12_tick;
    logic ext8_tick;
    logic ext_rise;
    logic cmp_rise;

    logic hi_ovf_flag, lo_ovf_flag, lo_ovf_irq_en, capture_en, split_sel, run_ctrl;
    logic [1:0] alt_clk_sel;
    logic alt_tick, cap_trig, cap_evt, lo_tick, hi_tick;
    logic lo_inc, hi_inc, lo_wrap, hi_wrap;
    logic wr_ctrl, wr_rld_lo, wr_rld_hi, wr_cnt_lo, wr_cnt_hi;
    logic [7:0] next_count_lo, next_count_hi;

    assign hi_ovf_flag = tmr_ctrl_reg[art_pkg::BIT_HI_OVF];
    assign lo_ovf_flag = tmr_ctrl_reg[art_pkg::BIT_LO_OVF];
    assign lo_ovf_irq_en = tmr_ctrl_reg[art_pkg::BIT_LO_IRQ_EN];
    assign capture_en = tmr_ctrl_reg[art_pkg::BIT_CAP_EN];
    assign split_sel = tmr_ctrl_reg[art_pkg::BIT_SPLIT];
    assign run_ctrl = tmr_ctrl_reg[art_pkg::BIT_RUN];
    assign alt_clk_sel = tmr_ctrl_reg[art_pkg::SEL_MSB:art_pkg::SEL_LSB];

    // address decode
    assign wr_ctrl = sfr_wr && (sfr_addr == art_pkg::ADDR_CTRL);
    assign wr_rld_lo = sfr_wr && (sfr_addr == art_pkg::ADDR_RLD_LO);
    assign wr_rld_hi = sfr_wr && (sfr_addr == art_pkg::ADDR_RLD_HI);
    assign wr_cnt_lo = sfr_wr && (sfr_addr == art_pkg::ADDR_CNT_LO);
    assign wr_cnt_hi = sfr_wr && (sfr_addr == art_pkg::ADDR_CNT_HI);

    // core clock set picks every cycle, clear picks the shared alternate source
    function automatic logic pick_tick(input logic core_clk_sel, input logic alt);
        pick_tick = core_clk_sel ? 1'b1 : alt; // [RL18]
    endfunction : pick_tick

    // external sources pass through synchronisers first
    art_sync_edge u_ext_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(ext_osc_in),
        .rise(ext_rise) // [RL14]
    );
    art_sync_edge u_cmp_sync (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(cmp_in),
        .rise(cmp_rise) // [RL14]
    );

    // core clock divided by twelve as a one-cycle enable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div12_cnt <= art_pkg::DIV_ZERO;
            sys12_tick <= 1'b0;
        end else begin
            sys12_tick <= (div12_cnt == art_pkg::DIV12_LAST);
            div12_cnt <= (div12_cnt == art_pkg::DIV12_LAST) ? art_pkg::DIV_ZERO
                                                              : div12_cnt + 4'h1;
        end
    end

    // external oscillator divided by eight, counted on synchronised edges
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div8_cnt <= art_pkg::DIV8_ZERO;
            ext8_tick <= 1'b0;
        end else begin
            ext8_tick <= ext_rise && (div8_cnt == art_pkg::DIV8_LAST);
            if (ext_rise) begin
                div8_cnt <= div8_cnt + 3'h1;
            end
        end
    end

    // alternate count source and capture trigger from the shared select
    always_comb begin
        case (alt_clk_sel)
            art_pkg::ALT_SYS12_A: alt_tick = sys12_tick; // [RL11]
            art_pkg::ALT_EXT8: alt_tick = ext8_tick;
            art_pkg::ALT_SYS12_B: alt_tick = sys12_tick;
            art_pkg::ALT_CMP: alt_tick = cmp_rise;
            default: alt_tick = 1'b0;
        endcase
        cap_trig = alt_clk_sel[art_pkg::SEL_MSB] ? ext8_tick : cmp_rise; // [RL12]
    end

    // split bytes share alt_tick but choose it per byte [RL13]
    assign lo_tick = pick_tick(lo_byte_core_clk_sel, alt_tick);
    assign hi_tick = pick_tick(hi_byte_core_clk_sel, alt_tick);
    assign cap_evt = capture_en && cap_trig; // [RL7]

    // increment enables: split gates only the upper byte with run
    always_comb begin
        if (split_sel) begin // [RL8]
            lo_inc = lo_tick; // [RL10]
            hi_inc = run_ctrl && hi_tick;
        end else begin
            lo_inc = run_ctrl && lo_tick; // [RL9]
            hi_inc = run_ctrl && lo_tick && (count_lo == art_pkg::BYTE_MAX);
        end
        lo_wrap = lo_inc && (count_lo == art_pkg::BYTE_MAX);
        hi_wrap = hi_inc && (count_hi == art_pkg::BYTE_MAX);
    end

    // next counter values; 16-bit capture mode wraps to zero since reload holds captures
    always_comb begin
        next_count_lo = count_lo + 8'h01; // [RL19]
        next_count_hi = count_hi + 8'h01;
        if (lo_wrap) begin
            if (split_sel) begin
                next_count_lo = reload_lo; // [RL16]
            end else if (hi_wrap && !capture_en) begin
                next_count_lo = reload_lo; // [RL15]
            end else begin
                next_count_lo = art_pkg::BYTE_ZERO;
            end
        end
        if (hi_wrap) begin
            next_count_hi = (split_sel || !capture_en) ? reload_hi : art_pkg::BYTE_ZERO;
        end
    end

    // counter bytes; a software write wins over a tick
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_lo <= art_pkg::BYTE_ZERO;
            count_hi <= art_pkg::BYTE_ZERO;
        end else begin
            if (wr_cnt_lo) begin
                count_lo <= sfr_wdata;
            end else if (lo_inc) begin
                count_lo <= next_count_lo;
            end
            if (wr_cnt_hi) begin
                count_hi <= sfr_wdata;
            end else if (hi_inc) begin
                count_hi <= next_count_hi;
            end
        end
    end

    // reload bytes; capture wins so no sample is lost under a racing write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reload_lo <= art_pkg::BYTE_ZERO;
            reload_hi <= art_pkg::BYTE_ZERO;
        end else if (cap_evt) begin
            reload_lo <= count_lo; // [RL17]
            reload_hi <= count_hi;
        end else begin
            if (wr_rld_lo) begin
                reload_lo <= sfr_wdata;
            end
            if (wr_rld_hi) begin
                reload_hi <= sfr_wdata;
            end
        end
    end

    // control register; hardware flag sets win over a clearing write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tmr_ctrl_reg <= art_pkg::CTRL_RESET;
        end else begin
            if (wr_ctrl) begin
                tmr_ctrl_reg <= sfr_wdata; // [RL4]
            end
            if (hi_wrap || cap_evt) begin
                tmr_ctrl_reg[art_pkg::BIT_HI_OVF] <= 1'b1; // [RL1] [RL2] [RL17]
            end
            if (lo_wrap) begin
                tmr_ctrl_reg[art_pkg::BIT_LO_OVF] <= 1'b1; // [RL5]
            end
        end
    end

    // interrupt request from the flags, registered
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= timer_irq_en
                && (hi_ovf_flag || (lo_ovf_irq_en && lo_ovf_flag)); // [RL3] [RL6]
        end
    end

    // read data; unmapped addresses return zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sfr_rdata <= art_pkg::BYTE_ZERO;
        end else if (sfr_rd) begin
            case (sfr_addr)
                art_pkg::ADDR_CTRL: sfr_rdata <= tmr_ctrl_reg;
                art_pkg::ADDR_RLD_LO: sfr_rdata <= reload_lo;
                art_pkg::ADDR_RLD_HI: sfr_rdata <= reload_hi;
                art_pkg::ADDR_CNT_LO: sfr_rdata <= count_lo;
                art_pkg::ADDR_CNT_HI: sfr_rdata <= count_hi;
                default: sfr_rdata <= art_pkg::BYTE_ZERO;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_hi_ovf_set: assert property (hi_wrap |=> hi_ovf_flag) // [RL1]
        else $error("high overflow did not set flag");
    a_word_wrap: assert property ( // [RL2]
        !split_sel && !capture_en && !sfr_wr && lo_wrap && hi_wrap
        |=> hi_ovf_flag && {count_hi, count_lo} == $past({reload_hi, reload_lo}))
        else $error("16-bit wrap did not reload and flag");
    a_irq_hi: assert property (timer_irq_en && hi_ovf_flag |=> irq_req) // [RL3]
        else $error("high flag did not request interrupt");
    a_flag_sticky: assert property (hi_ovf_flag && lo_ovf_flag && !wr_ctrl // [RL4]
        |=> hi_ovf_flag && lo_ovf_flag)
        else $error("flag cleared without software");
    a_lo_ovf_set: assert property (lo_wrap |=> lo_ovf_flag) // [RL5]
        else $error("low overflow did not set flag");
    a_irq_lo: assert property (timer_irq_en && lo_ovf_irq_en && lo_ovf_flag |=> irq_req) // [RL6]
        else $error("low flag did not request interrupt");
    a_no_irq: assert property (!timer_irq_en |=> !irq_req) // [RL3]
        else $error("interrupt without enable");
    a_capture_copy: assert property (cap_evt // [RL17]
        |=> {reload_hi, reload_lo} == $past({count_hi, count_lo}) && hi_ovf_flag)
        else $error("capture did not copy count");
    a_stop_count: assert property (!split_sel && !run_ctrl && !sfr_wr // [RL9]
        |=> $stable({count_hi, count_lo}))
        else $error("16-bit counter moved while stopped");
    a_split_lo_run: assert property ( // [RL10]
        split_sel && !run_ctrl && lo_tick && !lo_wrap && !sfr_wr
        |=> count_lo == $past(count_lo) + 8'h01 && $stable(count_hi))
        else $error("split low byte not free running");
    a_split_reload: assert property (split_sel && hi_wrap && !sfr_wr // [RL16]
        |=> count_hi == $past(reload_hi))
        else $error("split high byte did not reload");
    a_sys12_gap: assert property (sys12_tick |=> !sys12_tick [*8]) // [RL11]
        else $error("divide-by-twelve enable too frequent");

    c_word_wrap: cover property (!split_sel && lo_wrap && hi_wrap);
    c_split_hi: cover property (split_sel && hi_wrap);
    c_capture: cover property (cap_evt ##2 irq_req);
    c_lo_irq: cover property (lo_ovf_irq_en && lo_wrap ##2 irq_req);
endmodule : art_timer
`default_nettype wire

//--- auto_reload_timer_control_bench.sv
`default_nettype none
module auto_reload_timer_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic hi_byte_core_clk_sel = 1'b1;
    logic lo_byte_core_clk_sel = 1'b1;
    logic timer_irq_en = 1'b1;
    logic ext_osc_in = 1'b0;
    logic cmp_in = 1'b0;
    logic irq_req;
    int mismatches = 0;
    int n_checks = 0;
    logic [31:0] seed = 32'h88FEFC1F;
    logic [7:0] rv, rl, rh;
    int tol;

    art_timer dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .hi_byte_core_clk_sel(hi_byte_core_clk_sel), .lo_byte_core_clk_sel(lo_byte_core_clk_sel),
        .timer_irq_en(timer_irq_en), .ext_osc_in(ext_osc_in), .cmp_in(cmp_in),
        .irq_req(irq_req));

    // 40 ns system clock
    initial begin
        forever #20 clk = ~clk;
    end

    // xorshift keeps the random stream repeatable
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // ticks expected over n running cycles with e oscillator and c comparator edges
    function automatic int exp_ticks(input logic [1:0] sel, input int e, input int c, input int n);
        case (sel)
            art_pkg::ALT_EXT8: return e / 8;
            art_pkg::ALT_CMP: return c;
            default: return n / 12;
        endcase
    endfunction : exp_ticks

    task automatic rnd(output logic [7:0] v);
        seed = xs(seed);
        v = seed[7:0];
    endtask : rnd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input logic [7:0] got, input int lo, input int hi, input string what);
        n_checks++;
        if ($isunknown(got) || int'(got) < lo || int'(got) > hi) begin
            mismatches++;
            $display("wrong value at %0t: %s got %h want %0d..%0d", $time, what, got, lo, hi);
        end
    endtask : chk_rng

    // one-cycle strobes, driven just after the edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= 1'b1;
        @(posedge clk);
        sfr_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge clk);
        sfr_rd <= 1'b0;
        // read data stands until the next read, so take it at the following edge
        @(posedge clk);
        v = sfr_rdata;
    endtask : rd

    task automatic do_reset();
        @(posedge clk);
        rst_n <= 1'b0;
        cyc(4);
        rst_n <= 1'b1;
    endtask : do_reset

    // slow pulses on the asynchronous sources, six cycles each
    task automatic edges(input int e, input int c);
        for (int i = 0; i < e || i < c; i++) begin
            ext_osc_in <= (i < e);
            cmp_in <= (i < c);
            cyc(3);
            ext_osc_in <= 1'b0;
            cmp_in <= 1'b0;
            cyc(3);
        end
    endtask : edges

    // watchdog, far beyond the roughly one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        $display("wrong value at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        do_reset();
        // reset values and the unmapped hole
        for (int a = 8'h90; a <= 8'h96; a++) begin
            rd(8'(a), rv);
            chk(rv, art_pkg::CTRL_RESET, "reset value");
        end
        wr(8'h96, 8'hFF);
        rd(8'h96, rv);
        chk(rv, art_pkg::BYTE_ZERO, "unmapped read");
        for (int i = 0; i < 4; i++) begin
            rnd(rl);
            wr(art_pkg::ADDR_RLD_LO + 8'(i % 2), rl);
            rd(art_pkg::ADDR_RLD_LO + 8'(i % 2), rv);
            chk(rv, rl, "reload readback");
            wr(art_pkg::ADDR_CTRL, rl & 8'h3B);
            rd(art_pkg::ADDR_CTRL, rv);
            chk(rv, rl & 8'h3B, "control readback");
        end
        $display("test registers done");

        // 16-bit wrap with reload, flags kept until software clears them
        do_reset();
        rnd(rl);
        rnd(rh);
        rl = rl & 8'h7F;
        wr(art_pkg::ADDR_RLD_LO, rl);
        wr(art_pkg::ADDR_RLD_HI, rh);
        wr(art_pkg::ADDR_CNT_LO, art_pkg::BYTE_MAX - 8'h01);
        wr(art_pkg::ADDR_CNT_HI, art_pkg::BYTE_MAX);
        wr(art_pkg::ADDR_CTRL, 8'h04);
        cyc(4);
        rd(art_pkg::ADDR_CTRL, rv);
        chk(rv, 8'hC4, "both flags after wrap");
        chk({7'h00, irq_req}, 8'h01, "irq on overflow");
        wr(art_pkg::ADDR_CTRL, 8'hC0);
        rd(art_pkg::ADDR_CNT_HI, rv);
        chk(rv, rh, "reloaded high byte");
        rd(art_pkg::ADDR_CNT_LO, rv);
        chk_rng(rv, int'(rl), int'(rl) + 16, "reloaded low byte");
        cyc(20);
        rd(art_pkg::ADDR_CNT_LO, rl);
        chk(rl, rv, "stopped count");
        rd(art_pkg::ADDR_CTRL, rv);
        chk(rv, 8'hC0, "flags held");
        timer_irq_en <= 1'b0;
        cyc(3);
        chk({7'h00, irq_req}, 8'h00, "irq masked");
        timer_irq_en <= 1'b1;
        wr(art_pkg::ADDR_CTRL, 8'h00);
        cyc(3);
        chk({7'h00, irq_req}, 8'h00, "irq after clear");
        $display("test sixteen bit done");

        // split mode: low byte runs without the run bit, high byte needs it
        do_reset();
        rnd(rl);
        rnd(rh);
        rl = rl & 8'h7F;
        rh = rh & 8'h7F;
        wr(art_pkg::ADDR_RLD_LO, rl);
        wr(art_pkg::ADDR_RLD_HI, rh);
        wr(art_pkg::ADDR_CNT_LO, 8'hFC);
        wr(art_pkg::ADDR_CNT_HI, 8'hFE);
        wr(art_pkg::ADDR_CTRL, 8'h28);
        cyc(8);
        rd(art_pkg::ADDR_CTRL, rv);
        chk(rv, 8'h68, "low flag in split");
        chk({7'h00, irq_req}, 8'h01, "low byte irq");
        rd(art_pkg::ADDR_CNT_HI, rv);
        chk(rv, 8'hFE, "high byte idle");
        rd(art_pkg::ADDR_CNT_LO, rv);
        chk_rng(rv, int'(rl), int'(rl) + 24, "low byte reload");
        wr(art_pkg::ADDR_CTRL, 8'h48);
        cyc(3);
        chk({7'h00, irq_req}, 8'h00, "low irq disabled");
        wr(art_pkg::ADDR_CTRL, 8'h4C);
        cyc(4);
        rd(art_pkg::ADDR_CTRL, rv);
        chk(rv, 8'hCC, "high flag in split");
        rd(art_pkg::ADDR_CNT_HI, rv);
        chk_rng(rv, int'(rh), int'(rh) + 10, "high byte reload");
        $display("test split done");

        // every alternate source code, lower byte on the alternate source
        for (int s = 0; s < 4; s++) begin
            do_reset();
            lo_byte_core_clk_sel <= 1'b0;
            wr(art_pkg::ADDR_CTRL, 8'h04 | 8'(s));
            edges(24, 24);
            cyc(6);
            wr(art_pkg::ADDR_CTRL, 8'(s));
            rd(art_pkg::ADDR_CNT_LO, rv);
            tol = (s % 2 == 0) ? 1 : 0;
            rh = 8'(exp_ticks(2'(s), 24, 24, 152));
            chk_rng(rv, int'(rh) - tol, int'(rh) + tol, "alternate ticks");
        end
        // split bytes share the comparator; run stops only the upper byte
        do_reset();
        hi_byte_core_clk_sel <= 1'b0;
        lo_byte_core_clk_sel <= 1'b0;
        wr(art_pkg::ADDR_CTRL, 8'h0F);
        edges(0, 5);
        wr(art_pkg::ADDR_CTRL, 8'h0B);
        edges(0, 1);
        cyc(4);
        rd(art_pkg::ADDR_CNT_LO, rv);
        chk(rv, 8'h06, "split low on comparator");
        rd(art_pkg::ADDR_CNT_HI, rv);
        chk(rv, 8'h05, "split high on comparator");
        hi_byte_core_clk_sel <= 1'b1;
        lo_byte_core_clk_sel <= 1'b1;
        $display("test sources done");

        // capture on comparator, then on oscillator divided by 8
        do_reset();
        wr(art_pkg::ADDR_CTRL, 8'h15);
        edges(0, 1);
        rd(art_pkg::ADDR_CTRL, rv);
        chk(rv, 8'h95, "capture flag");
        rd(art_pkg::ADDR_RLD_HI, rv);
        chk(rv, art_pkg::BYTE_ZERO, "captured high");
        rd(art_pkg::ADDR_RLD_LO, rv);
        chk_rng(rv, 1, 24, "captured low");
        wr(art_pkg::ADDR_CTRL, 8'h16);
        edges(7, 7);
        rd(art_pkg::ADDR_CTRL, rv);
        chk(rv, 8'h16, "no early capture");
        edges(1, 0);
        cyc(2);
        rd(art_pkg::ADDR_CTRL, rv);
        chk(rv, 8'h96, "eighth edge capture");
        $display("test capture done");
        stop_test();
    end
endmodule : auto_reload_timer_control_bench
`default_nettype wire
